// >>> inc/sptr_pkg.sv
// Package of constants and types for the stepper phase translator
package sptr_pkg;
   // Clock and time base
   localparam int unsigned CLK_HZ          = 50000000;   // pclk rate
   localparam int unsigned RATE_W          = 16;         // Width of rate fields
   localparam int unsigned ACC_W           = 32;         // Phase accumulator width
   // Rate limits in steps per second
   localparam logic [15:0] START_MAX_FULL  = 16'h03E8;   // 1000 full steps/s
   localparam logic [15:0] START_MAX_FINE  = 16'h07D0;   // 2000 half steps/s
   localparam logic [15:0] SLEW_MIN_FULL   = 16'h00C8;   // 200 steps/s
   localparam logic [15:0] SLEW_MAX_FULL   = 16'h2710;   // 10,000 steps/s
   localparam logic [15:0] SLEW_MIN_FINE   = 16'h0190;   // 400 steps/s
   localparam logic [15:0] SLEW_MAX_FINE   = 16'h4E20;   // 20,000 steps/s
   // Ramp: rate changes by one step/s every RAMP_TICK_US microseconds
   localparam int unsigned RAMP_TICK_US    = 50;
   localparam int unsigned RAMP_TICK_CYC   = (RAMP_TICK_US * (CLK_HZ / 1000000));
   localparam logic [15:0] RAMP_TICK_LAST  = 16'(RAMP_TICK_CYC - 1);
   // Reset defaults
   localparam logic [15:0] START_RST       = 16'h0064;   // 100 steps/s
   localparam logic [15:0] SLEW_RST        = 16'h03E8;   // 1000 steps/s
   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_START       = 8'h04;
   localparam logic [7:0]  OFS_SLEW        = 8'h08;
   localparam logic [7:0]  OFS_STATUS      = 8'h0C;
   localparam logic [7:0]  OFS_INT_STAT    = 8'h10;
   localparam logic [7:0]  OFS_INT_MASK    = 8'h14;
   // Interrupt bit positions
   localparam int unsigned IB_FAULT        = 0;
   localparam int unsigned IB_HOT          = 1;
   localparam int unsigned IB_STOP         = 2;
   localparam int unsigned INT_W           = 3;
   // Winding pattern index width (eight states)
   localparam int unsigned PH_W            = 3;
   // Winding leads {1,3,4,5} per state index, clockwise order
   localparam logic [3:0]  PAT_0           = 4'h1;       // 5 only
   localparam logic [3:0]  PAT_1           = 4'h9;       // 1+5
   localparam logic [3:0]  PAT_2           = 4'h8;       // 1 only
   localparam logic [3:0]  PAT_3           = 4'hA;       // 1+4
   localparam logic [3:0]  PAT_4           = 4'h2;       // 4 only
   localparam logic [3:0]  PAT_5           = 4'h6;       // 3+4
   localparam logic [3:0]  PAT_6           = 4'h4;       // 3 only
   localparam logic [3:0]  PAT_7           = 4'h5;       // 3+5
   // Oscillator modes, Gray coded along idle-start-ramp path
   typedef enum logic [1:0] {
      SPTR_IDLE  = 2'b00,
      SPTR_START = 2'b01,
      SPTR_UP    = 2'b11,
      SPTR_DOWN  = 2'b10
   } sptr_osc_t;
endpackage

// >>> rtl/sptr_top.sv
// Stepper phase translator: step decoding, winding pattern, oscillator, monitors
// Function
// - Fine mode walks eight winding states clockwise
// - Counterclockwise walks the states in reverse
// - Forward step pulse advances one state clockwise
// - Reverse step pulse advances one state counterclockwise
// - Fine select: eight states, else four
// - Every oscillator pulse appears on pulse output
// - Undervoltage latches fault output until reset
// - Over-temperature output follows thermal switch
// - Start select runs oscillator at start rate
// - Slew rate range limited per step mode
// - Slew select ramps up; release ramps down, stops
// - Start or slew select runs the oscillator
// - Forward pulses reverse when reverse select active
// - Control pins active low
`timescale 1ns/1ns
module sptr_top
   import sptr_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        fwd_step_in_n,       // Forward step pulse pin, low active
   input  wire logic        rev_step_in_n,       // Reverse step pulse pin, low active
   input  wire logic        reverse_dir_select_n,// Direction pin, low active
   input  wire logic        fine_step_select_n,  // Eight-state select, low active
   input  wire logic        start_rate_select_n, // Start-rate oscillator run, low active
   input  wire logic        slew_rate_select_n,  // Ramped oscillator run, low active
   input  wire logic        supply_low,          // Undervoltage detector, high = low supply
   input  wire logic        heat_switch,         // Thermal switch, high = hot
   output logic      [3:0]  winding_out,         // Leads {1,3,4,5}, high = energised
   output logic             osc_pulse_out,       // Oscillator step pulse, one cycle
   output logic             fault_out,           // Latched supply fault
   output logic             over_temp_out,       // Thermal state
   output logic             irq                  // Level interrupt
);

   localparam int unsigned NSYNC = 8;            // Pins through the synchronisers

   // Synchroniser stages: stage one feeds only stage two
   logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff;
   logic [NSYNC-1:0] pin_raw;                    // Raw pins, active high
   logic [NSYNC-1:0] pin_ff;                     // Accepted levels
   logic [NSYNC-1:0] pin_prev_ff;                // Previous accepted levels

   // Control pins inverted to active high at the boundary
   assign pin_raw = {heat_switch, supply_low, ~slew_rate_select_n, ~start_rate_select_n,
                     ~fine_step_select_n, ~reverse_dir_select_n, ~rev_step_in_n,
                     ~fwd_step_in_n};

   // Three-stage synchroniser on every pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= pin_raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // A change counts only once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_ff      <= '0;
         pin_prev_ff <= '0;
      end else begin
         pin_prev_ff <= pin_ff;
         for (int i = 0; i < NSYNC; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               pin_ff[i] <= s3_ff[i];
            end
         end
      end
   end

   logic fwd_lvl, rev_lvl, dir_rev, fine_sel, start_sel, slew_sel, sup_low, hot;
   assign fwd_lvl   = pin_ff[0];
   assign rev_lvl   = pin_ff[1];
   assign dir_rev   = pin_ff[2];
   assign fine_sel  = pin_ff[3];
   assign start_sel = pin_ff[4];
   assign slew_sel  = pin_ff[5];
   assign sup_low   = pin_ff[6];
   assign hot       = pin_ff[7];

   // Register bank
   logic             sw_run_ff;                  // Software oscillator enable
   logic             sw_loop_ff;                 // Loop oscillator into forward input
   logic [RATE_W-1:0] start_rate_ff;             // Start rate, steps/s
   logic [RATE_W-1:0] slew_rate_ff;              // Slew rate, steps/s
   logic [INT_W-1:0] int_stat_ff;                // Sticky events
   logic [INT_W-1:0] int_mask_ff;                // Enable per event

   logic wr_en, rd_en;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;

   // Zero-wait slave
   assign pready = 1'b1;

   logic addr_ok;
   always_comb begin
      case (paddr)
         OFS_CTRL, OFS_START, OFS_SLEW, OFS_STATUS, OFS_INT_STAT, OFS_INT_MASK: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   // Unmapped offsets answer with an error
   assign pslverr = psel & penable & ~addr_ok;

   // Rate clamps for the present step mode
   logic [RATE_W-1:0] start_max, slew_min, slew_max;
   assign start_max = fine_sel ? START_MAX_FINE : START_MAX_FULL;
   assign slew_min  = fine_sel ? SLEW_MIN_FINE  : SLEW_MIN_FULL;
   assign slew_max  = fine_sel ? SLEW_MAX_FINE  : SLEW_MAX_FULL;

   logic [RATE_W-1:0] start_eff, slew_eff;
   assign start_eff = (start_rate_ff > start_max) ? start_max : start_rate_ff;
   always_comb begin
      if (slew_rate_ff < slew_min) begin
         slew_eff = slew_min;
      end else if (slew_rate_ff > slew_max) begin
         slew_eff = slew_max;
      end else begin
         slew_eff = slew_rate_ff;
      end
   end

   // Control and rate registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_run_ff     <= 1'b0;
         sw_loop_ff    <= 1'b0;
         start_rate_ff <= START_RST;
         slew_rate_ff  <= SLEW_RST;
         int_mask_ff   <= '0;
      end else if (wr_en) begin
         case (paddr)
            OFS_CTRL: begin
               sw_run_ff  <= pwdata[0];
               sw_loop_ff <= pwdata[1];
            end
            OFS_START:    start_rate_ff <= pwdata[RATE_W-1:0];
            OFS_SLEW:     slew_rate_ff  <= pwdata[RATE_W-1:0];
            OFS_INT_MASK: int_mask_ff   <= pwdata[INT_W-1:0];
            default: ;
         endcase
      end
   end

   // Oscillator: rate-controlled phase accumulator with ramp
   sptr_osc_t         osc_ff, nxt_osc;
   logic [RATE_W-1:0] rate_ff;                   // Present step rate
   logic [ACC_W-1:0]  acc_ff;                    // Phase accumulator
   logic [RATE_W-1:0] tick_ff;                   // Ramp tick counter
   logic              osc_stop_pulse;            // Ramp finished
   logic              run_start, run_slew;

   // Pins or software control both start the oscillator
   assign run_start = start_sel | (sw_run_ff & ~slew_sel);
   assign run_slew  = slew_sel;

   // Mode selection
   always_comb begin
      nxt_osc = osc_ff;
      case (osc_ff)
         SPTR_IDLE: begin
            if (run_slew) begin
               nxt_osc = SPTR_UP;
            end else if (run_start) begin
               nxt_osc = SPTR_START;
            end
         end
         SPTR_START: begin
            if (run_slew) begin
               nxt_osc = SPTR_UP;
            end else if (!run_start) begin
               nxt_osc = SPTR_IDLE;
            end
         end
         SPTR_UP: begin
            if (!run_slew) begin
               nxt_osc = SPTR_DOWN;
            end
         end
         SPTR_DOWN: begin
            if (run_slew) begin
               nxt_osc = SPTR_UP;
            end else if (rate_ff <= start_eff) begin
               nxt_osc = SPTR_IDLE;
            end
         end
         default: nxt_osc = SPTR_IDLE;
      endcase
   end

   assign osc_stop_pulse = (osc_ff == SPTR_DOWN) && (nxt_osc == SPTR_IDLE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_ff <= SPTR_IDLE;
      end else begin
         osc_ff <= nxt_osc;
      end
   end

   // Ramp tick: rate moves one step/s per tick
   logic ramp_tick;
   assign ramp_tick = (tick_ff == RAMP_TICK_LAST);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_ff <= '0;
      end else if (ramp_tick) begin
         tick_ff <= '0;
      end else begin
         tick_ff <= tick_ff + 16'h0001;
      end
   end

   // Rate: start rate directly, or ramped toward the slew rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_ff <= '0;
      end else begin
         case (osc_ff)
            SPTR_START: rate_ff <= start_eff;
            SPTR_UP: begin
               if (rate_ff < start_eff) begin
                  rate_ff <= start_eff;
               end else if (ramp_tick && rate_ff < slew_eff) begin
                  rate_ff <= rate_ff + 16'h0001;
               end else if (rate_ff > slew_eff) begin
                  rate_ff <= slew_eff;
               end
            end
            SPTR_DOWN: begin
               if (ramp_tick && rate_ff > start_eff) begin
                  rate_ff <= rate_ff - 16'h0001;
               end
            end
            default: rate_ff <= start_eff;
         endcase
      end
   end

   // Phase accumulator emits one pulse per wrap of CLK_HZ
   logic [ACC_W-1:0] acc_sum;
   logic             acc_wrap;
   logic             osc_active;
   assign osc_active = (osc_ff != SPTR_IDLE);
   assign acc_sum    = acc_ff + ACC_W'(rate_ff);
   assign acc_wrap   = osc_active && (acc_sum >= ACC_W'(CLK_HZ));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_ff        <= '0;
         osc_pulse_out <= 1'b0;
      end else begin
         osc_pulse_out <= acc_wrap;
         if (!osc_active) begin
            acc_ff <= '0;
         end else if (acc_wrap) begin
            acc_ff <= acc_sum - ACC_W'(CLK_HZ);
         end else begin
            acc_ff <= acc_sum;
         end
      end
   end

   // Step decode: forward input may take the looped oscillator pulse
   logic fwd_edge, rev_edge, step_cw, step_ccw;
   assign fwd_edge = (fwd_lvl & ~pin_prev_ff[0]) | (sw_loop_ff & osc_pulse_out);
   assign rev_edge = rev_lvl & ~pin_prev_ff[1];
   // Reverse select turns forward pulses counterclockwise
   assign step_cw  = fwd_edge & ~dir_rev & ~rev_edge;
   assign step_ccw = (rev_edge | (fwd_edge & dir_rev)) & ~(fwd_edge & ~dir_rev);

   // Winding state index; full mode uses only the odd (two-on) states
   logic [PH_W-1:0] phase_ff, step_size;
   assign step_size = fine_sel ? 3'h1 : 3'h2;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ff <= 3'h1;
      end else if (step_cw) begin
         // Full mode forces onto a two-on state first
         phase_ff <= (phase_ff + step_size) | (fine_sel ? 3'h0 : 3'h1);
      end else if (step_ccw) begin
         phase_ff <= (phase_ff - step_size) | (fine_sel ? 3'h0 : 3'h1);
      end
   end

   // Winding pattern lookup, registered
   logic [3:0] nxt_winding;
   always_comb begin
      case (phase_ff)
         3'h0: nxt_winding = PAT_0;
         3'h1: nxt_winding = PAT_1;
         3'h2: nxt_winding = PAT_2;
         3'h3: nxt_winding = PAT_3;
         3'h4: nxt_winding = PAT_4;
         3'h5: nxt_winding = PAT_5;
         3'h6: nxt_winding = PAT_6;
         3'h7: nxt_winding = PAT_7;
         default: nxt_winding = PAT_1;
      endcase
   end

   // Monitors and outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         winding_out   <= '0;
         fault_out     <= 1'b0;
         over_temp_out <= 1'b0;
      end else begin
         winding_out   <= nxt_winding;
         over_temp_out <= hot;
         if (sup_low) begin
            fault_out <= 1'b1;
         end
      end
   end

   // Sticky interrupt status; a new event wins over a clear
   logic [INT_W-1:0] events;
   assign events = {osc_stop_pulse, hot & ~pin_prev_ff[7], sup_low & ~pin_prev_ff[6]};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_ff <= '0;
      end else if (wr_en && paddr == OFS_INT_STAT) begin
         int_stat_ff <= (int_stat_ff & ~pwdata[INT_W-1:0]) | events;
      end else begin
         int_stat_ff <= int_stat_ff | events;
      end
   end

   assign irq = |(int_stat_ff & int_mask_ff);

   // Read data, registered in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            OFS_CTRL:     prdata <= {30'h0, sw_loop_ff, sw_run_ff};
            OFS_START:    prdata <= {16'h0, start_rate_ff};
            OFS_SLEW:     prdata <= {16'h0, slew_rate_ff};
            OFS_STATUS:   prdata <= {8'h0, rate_ff, 1'b0, phase_ff, osc_ff, dir_rev, fine_sel};
            OFS_INT_STAT: prdata <= {29'h0, int_stat_ff};
            OFS_INT_MASK: prdata <= {29'h0, int_mask_ff};
            default:      prdata <= '0;
         endcase
      end
   end

endmodule

// >>> test/sptr_indexer.sv
// Behavioural step-pulse source standing in for the external indexer
`timescale 1ns/1ns
module sptr_indexer (
   input  wire logic pclk,
   output logic      fwd_step_in_n = 1'b1,  // Idle high, pulled up
   output logic      rev_step_in_n = 1'b1   // Idle high
);
   // One pulse: low lo cycles, then high hi cycles
   // Both pins at once is refused while reverse select is off, sent on purpose
   // Closely spaced pulses, far above any start rate: no ramp
   task automatic step(input logic f, input logic r, input int lo, input int hi);
      @(posedge pclk);
      fwd_step_in_n <= !f;                  // Asserted by pulling low
      rev_step_in_n <= !r;
      repeat (lo) @(posedge pclk);
      fwd_step_in_n <= 1'b1;
      rev_step_in_n <= 1'b1;
      repeat (hi) @(posedge pclk);
   endtask
endmodule

// >>> test/sptr_top_sva.sv
// Port-level assertion checker for the stepper phase translator
`timescale 1ns/1ns
module sptr_top_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        fwd_step_in_n,
   input wire logic        rev_step_in_n,
   input wire logic        fine_step_select_n,
   input wire logic        supply_low,
   input wire logic        heat_switch,
   input wire logic [3:0]  winding_out,
   input wire logic        osc_pulse_out,
   input wire logic        fault_out,
   input wire logic        over_temp_out
);
   logic [7:0]  stp_cnt_ff;  // Step pin fall age
   logic [7:0]  sup_cnt_ff;  // Supply-low age
   logic [15:0] osc_cnt_ff;  // Oscillator pulse age
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Clockwise walk place of a pattern
   function automatic logic [2:0] pos(input logic [3:0] w);
      case (w)
         4'h9: pos = 3'h1;
         4'h8: pos = 3'h2;
         4'hA: pos = 3'h3;
         4'h2: pos = 3'h4;
         4'h6: pos = 3'h5;
         4'h4: pos = 3'h6;
         4'h5: pos = 3'h7;
         default: pos = 3'h0;
      endcase
   endfunction
   // Step edge age
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) stp_cnt_ff <= 8'hFF;
      else if ($fell(fwd_step_in_n) || $fell(rev_step_in_n)) stp_cnt_ff <= 8'h00;
      else if (stp_cnt_ff != 8'hFF) stp_cnt_ff <= stp_cnt_ff + 8'h01;
   end
   // Supply-low age
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sup_cnt_ff <= 8'hFF;
      else if (supply_low) sup_cnt_ff <= 8'h00;
      else if (sup_cnt_ff != 8'hFF) sup_cnt_ff <= sup_cnt_ff + 8'h01;
   end
   // Oscillator pulse spacing, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) osc_cnt_ff <= 16'hFFFF;
      else if (osc_pulse_out) osc_cnt_ff <= 16'h0000;
      else if (osc_cnt_ff != 16'hFFFF) osc_cnt_ff <= osc_cnt_ff + 16'h0001;
   end
   property p_fine_adj;
      $changed(winding_out) && $past(winding_out) != 4'h0 && !fine_step_select_n
      |-> 3'(pos(winding_out) - pos($past(winding_out))) inside {3'h1, 3'h7};
   endproperty
   a_fine_adj: assert property (p_fine_adj) else $error("fine step not to a neighbour");
   property p_full_odd;
      $changed(winding_out) && $past(winding_out) != 4'h0 && fine_step_select_n
      |-> winding_out inside {4'h9, 4'hA, 4'h6, 4'h5};
   endproperty
   a_full_odd: assert property (p_full_odd) else $error("full step left two-on states");
   property p_step_cause;
      $changed(winding_out) && $past(winding_out) != 4'h0 |-> stp_cnt_ff <= 8'h0C;
   endproperty
   a_step_cause: assert property (p_step_cause) else $error("winding moved without a pulse");
   property p_fault_hold;
      fault_out |=> fault_out;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault dropped");
   property p_fault_cause;
      $rose(fault_out) |-> sup_cnt_ff <= 8'h08;
   endproperty
   a_fault_cause: assert property (p_fault_cause) else $error("fault with good supply");
   property p_hot_on;
      heat_switch [*8] |-> over_temp_out;
   endproperty
   a_hot_on: assert property (p_hot_on) else $error("hot switch not shown");
   property p_hot_off;
      !heat_switch [*8] |-> !over_temp_out;
   endproperty
   a_hot_off: assert property (p_hot_off) else $error("cool switch not shown");
   property p_osc_gap;
      osc_pulse_out |-> osc_cnt_ff >= 16'h09C3;
   endproperty
   a_osc_gap: assert property (p_osc_gap) else $error("oscillator above top rate");
   property p_pready;
      psel |-> pready;
   endproperty
   a_pready: assert property (p_pready) else $error("pready low");
   property p_slverr;
      psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h14);
   endproperty
   a_slverr: assert property (p_slverr) else $error("pslverr wrong for address");
   c_fault: cover property ($rose(fault_out));
   c_osc: cover property (osc_pulse_out);
   c_full: cover property ($changed(winding_out) && fine_step_select_n);
endmodule
bind sptr_top sptr_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .fwd_step_in_n(fwd_step_in_n),
   .rev_step_in_n(rev_step_in_n), .fine_step_select_n(fine_step_select_n), .supply_low(supply_low),
   .heat_switch(heat_switch), .winding_out(winding_out), .osc_pulse_out(osc_pulse_out),
   .fault_out(fault_out), .over_temp_out(over_temp_out));

// >>> test/sptr_top_tb.sv
// Self-checking bench for the stepper phase translator
`timescale 1ns/1ns
module sptr_top_tb
   import sptr_pkg::*;
();
   typedef struct packed {logic [32:0] e; logic [32:0] m;} sptr_exp_t; // Read word and care mask
   localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, fwd_n, rev_n, osc_pulse_out, fault_out, over_temp_out, irq;
   logic        rdir_n = 1'b1, start_n = 1'b1, slew_n = 1'b1;
   logic        fine_n = 1'b0;                    // Mode fixed before any stepping
   logic        supply_low = 1'b0, heat_switch = 1'b0;
   logic [3:0]  winding_out, w_last, we;
   logic [3:0]  pat [8] = '{4'h1, 4'h9, 4'h8, 4'hA, 4'h2, 4'h6, 4'h4, 4'h5}; // Clockwise walk
   logic [3:0]  wq [$];                           // Expected winding patterns
   sptr_exp_t   rq [$], re;                       // Expected read words
   int          failures = 0, n_compared = 0, seed = 78170, ph = 1, n;
   always #10 pclk = ~pclk;
   sptr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fwd_step_in_n(fwd_n), .rev_step_in_n(rev_n), .reverse_dir_select_n(rdir_n),
      .fine_step_select_n(fine_n), .start_rate_select_n(start_n), .slew_rate_select_n(slew_n),
      .supply_low(supply_low), .heat_switch(heat_switch), .winding_out(winding_out),
      .osc_pulse_out(osc_pulse_out), .fault_out(fault_out), .over_temp_out(over_temp_out), .irq(irq));
   sptr_indexer idx_u (.pclk(pclk), .fwd_step_in_n(fwd_n), .rev_step_in_n(rev_n));
   task automatic fail(input string s, input logic [32:0] e, input logic [32:0] v);
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, e, v);
   endtask
   task automatic report_and_stop();
      if (failures == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic stop(input string s);
      fail(s, 33'h1, 33'h0);
      report_and_stop();
   endtask
   task automatic chk(input string s, input logic e, input logic v);
      n_compared++;
      if (v !== e) fail(s, {32'h0, e}, {32'h0, v});
   endtask
   // Wait, then look where outputs are settled
   task automatic settle(input int c);
      repeat (c) @(posedge pclk);
      @(negedge pclk);
   endtask
   // One APB transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
      if (k >= 20) stop("pready");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      rq.push_back('{e, m});
      apb(1'b0, a, 32'h0);
   endtask
   // Note the expected state, then send a random-width pulse
   task automatic stp(input logic f, input logic r, input int d);
      ph = (ph + d) & 7;
      if (d != 0) wq.push_back(pat[ph]);
      idx_u.step(f, r, 4 + ($random(seed) & 3), 4 + ($random(seed) & 3));
   endtask
   task automatic drain();
      int k;
      k = 0;
      while (wq.size() != 0 && k < 100) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 100) stop("winding_out late");
   endtask
   task automatic wosc(output int c);
      c = 0;
      do @(posedge pclk); while (osc_pulse_out !== 1'b1 && ++c < 60000);
      if (c >= 60000) stop("osc_pulse_out");
   endtask
   // Winding watcher
   always @(negedge pclk) begin
      if (presetn && winding_out !== w_last) begin
         n_compared++;
         if (wq.size() == 0) fail("winding_out extra", 33'h0, {29'h0, winding_out});
         else begin
            we = wq.pop_front();
            if (we !== winding_out) fail("winding_out", {29'h0, we}, {29'h0, winding_out});
         end
      end
      w_last = winding_out;
   end
   // Read watcher: masked compare with the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         re = rq.pop_front();
         n_compared++;
         if (({pslverr, prdata} & re.m) !== (re.e & re.m)) fail("prdata", re.e & re.m, {pslverr, prdata} & re.m);
      end
   end
   initial begin
      repeat (95000) @(posedge pclk);
      stop("run time");
   end
   initial begin
      wq.push_back(pat[1]);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20, 33'h1_0000_0000, ALL);
      rd(OFS_CTRL, 33'h0, ALL);
      rd(OFS_START, 33'h64, ALL);
      rd(OFS_SLEW, 33'h3E8, ALL);
      rd(OFS_INT_STAT, 33'h0, ALL);
      rd(OFS_STATUS, 33'h11, 33'h7F);
      for (int i = 0; i < 8; i++) stp(1'b1, 1'b0, 1);
      stp(1'b0, 1'b1, -1);
      stp(1'b0, 1'b1, -1);
      drain();
      @(posedge pclk) fine_n <= 1'b1;
      repeat (8) @(posedge pclk);
      stp(1'b1, 1'b0, 2);
      stp(1'b1, 1'b1, 0);
      @(posedge pclk) rdir_n <= 1'b0;
      repeat (8) @(posedge pclk);
      stp(1'b1, 1'b0, -2);
      rd(OFS_STATUS, 33'h2, 33'h3);
      @(posedge pclk) rdir_n <= 1'b1;
      repeat (8) @(posedge pclk);
      for (int i = 0; i < 6; i++) begin
         if ($random(seed) & 1) stp(1'b1, 1'b0, 2);
         else stp(1'b0, 1'b1, -2);
      end
      drain();
      @(posedge pclk) fine_n <= 1'b0;
      @(posedge pclk) supply_low <= 1'b1;
      repeat (6) @(posedge pclk);
      supply_low <= 1'b0;
      settle(10);
      chk("fault_out", 1'b1, fault_out);
      rd(OFS_INT_STAT, 33'h1, 33'h1);
      wr(OFS_INT_MASK, 32'h1);
      settle(0);
      chk("irq", 1'b1, irq);
      wr(OFS_INT_MASK, 32'h0);
      settle(0);
      chk("irq", 1'b0, irq);
      wr(OFS_INT_MASK, 32'h7);
      wr(OFS_INT_STAT, 32'h1);
      settle(0);
      chk("irq", 1'b0, irq);
      chk("fault_out", 1'b1, fault_out);
      @(posedge pclk) heat_switch <= 1'b1;
      settle(10);
      chk("over_temp_out", 1'b1, over_temp_out);
      chk("irq", 1'b1, irq);
      @(posedge pclk) heat_switch <= 1'b0;
      settle(10);
      chk("over_temp_out", 1'b0, over_temp_out);
      wr(OFS_INT_STAT, 32'h7);
      settle(0);
      chk("irq", 1'b0, irq);
      wr(OFS_START, 32'h2710);
      @(posedge pclk) start_n <= 1'b0;
      wosc(n);
      wosc(n);
      n_compared++;
      if (n < 24994 || n > 25004) fail("osc period", 33'h61A7, 33'(n));
      rd(OFS_STATUS, 33'h7D004, 33'hFFFF0C);
      @(posedge pclk) start_n <= 1'b1;
      wr(OFS_SLEW, 32'hFFFF);
      @(posedge pclk) slew_n <= 1'b0;
      repeat (6000) @(posedge pclk);
      rd(OFS_STATUS, 33'hC, 33'hC);
      @(posedge pclk) slew_n <= 1'b1;
      repeat (20) @(posedge pclk);
      rd(OFS_STATUS, 33'h8, 33'hC);
      repeat (12000) @(posedge pclk);
      rd(OFS_STATUS, 33'h0, 33'hC);
      rd(OFS_INT_STAT, 33'h4, 33'h4);
      settle(0);
      chk("irq", 1'b1, irq);
      drain();
      report_and_stop();
   end
endmodule
